// file: core/ftas_core.sv
// Purpose: CPU-side register core of a fast 10-bit timer with the shared timer flags
// Assumes: One clock; the fast side is modelled as a delayed path in the same clock
// Notes: I/O reads answer one cycle after the strobe
// Notes on behaviour
// - One shared two-bit high-bits buffer
// - Low-byte read copies upper bits to buffer
// - Low-byte write takes upper bits from buffer
// - Ten-bit counter, eight-bit when uppers zero
// - Top compare clears the counter on match
// - Compares A, B, D drive pins, flags
// - Five fast interrupt sources, each maskable
// - Fast side behind a synchronisation boundary
// - CPU writes reach counter after sync delay
// - Control and compare read back immediately
// - Counter, buffer, fast flags read delayed
// - Slow match A flag, also sixteen-bit
// - Slow match B flag, not when high
// - Flags clear on vector or written one
// - Slow overflow flag sets on overflow
// - Capture flag on edge or at TOP
// - Interrupt needs global, enable and flag
// - Bottom 0x00, max 0xFF, top by mode
`timescale 1ns/1ps
`default_nettype none
`include "ftas_consts.svh"
module ftas_core #(
	parameter int SYNC_DEPTH = `FTAS_SYNC_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [5:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic global_irq_enable,
	input wire logic [8:0] irq_vector_ack,
	input wire logic capture_input_pin,
	input wire logic fault_in,
	output logic [8:0] irq_pending,
	output logic fast_wave_out_a,
	output logic fast_wave_out_b,
	output logic fast_wave_out_d
);
	import ftas_pkg::*;

	logic [1:0] high_bits_buffer_r;
	logic [7:0] fast_ctrl_a_r, fast_ctrl_b_r, fast_ctrl_c_r, fast_ctrl_d_r;
	logic [9:0] cmp_a_sh_r, cmp_b_sh_r, top_sh_r, cmp_d_sh_r;
	logic [9:0] fast_counter_value_r, fa_r, fb_r, ftop_r, fd_r;
	logic [7:0] timer_irq_mask_r, timer_interrupt_flags_r, timer_interrupt_flags_set;
	logic fault_protect_flag_r, slow_ctrl_ctc, slow_run, slow_wide, slow_capm;
	logic [7:0] slow_ctrl_r, slow_compare_a_r, slow_compare_b_r;
	logic [15:0] slow_cnt_r, slow_top;
	logic cap_prev_r, cap_edge, wr_timer_interrupt_flags, fast_run, fast_at_top;
	logic [7:0] rdata_nxt;
	logic [1:0] hb_nxt;
	ftas_wtgt_t wtgt;
	logic [9:0] fcnt_seen;
	logic [3:0] fflags_seen;
	logic [1:0] hb_seen;

	ftas_sync_if #(.W(13)) wpipe_in ();
	ftas_sync_if #(.W(13)) wpipe_out ();
	ftas_sync_if #(.W(16)) rpipe_in ();
	ftas_sync_if #(.W(16)) rpipe_out ();

	assign fast_run = fast_ctrl_b_r[`FTAS_B_FRUN];
	assign slow_ctrl_ctc = slow_ctrl_r[`FTAS_B_SCTC];
	assign slow_run = slow_ctrl_r[`FTAS_B_SRUN];
	assign slow_wide = slow_ctrl_r[`FTAS_B_SWIDE];
	assign slow_capm = slow_ctrl_r[`FTAS_B_SCAPM];
	assign wr_timer_interrupt_flags = io_wr && io_addr == `FTAS_A_TIMER_INTERRUPT_FLAGS;
	assign cap_edge = capture_input_pin && !cap_prev_r;

	////////////////////////////////////////////////////////////////
	// Write target decode for the synchronised path
	always_comb begin
		if (!io_wr) wtgt = FTAS_W_NONE;
		else if (io_addr == `FTAS_A_CNT) wtgt = FTAS_W_CNT;
		else if (io_addr == `FTAS_A_CMP_A) wtgt = FTAS_W_CMP_A;
		else if (io_addr == `FTAS_A_CMP_B) wtgt = FTAS_W_CMP_B;
		else if (io_addr == `FTAS_A_TOP) wtgt = FTAS_W_TOP;
		else if (io_addr == `FTAS_A_CMP_D) wtgt = FTAS_W_CMP_D;
		else wtgt = FTAS_W_NONE;
	end

	assign wpipe_in.valid = wtgt != FTAS_W_NONE;
	assign wpipe_in.data = {wtgt, high_bits_buffer_r, io_wdata};
	assign rpipe_in.valid = 1'b1;
	assign rpipe_in.data = {fast_counter_value_r, timer_interrupt_flags_r[7:5],
		timer_interrupt_flags_r[`FTAS_B_FOVF], high_bits_buffer_r};
	assign fcnt_seen = rpipe_out.data[15:6];
	assign fflags_seen = rpipe_out.data[5:2];
	assign hb_seen = rpipe_out.data[1:0];

	ftas_sync_stage #(.W(13), .DEPTH(SYNC_DEPTH)) u_wsync (
		.clk(clk), .nrst(nrst), .din(wpipe_in), .dout(wpipe_out));
	ftas_sync_stage #(.W(16), .DEPTH(SYNC_DEPTH)) u_rsync (
		.clk(clk), .nrst(nrst), .din(rpipe_in), .dout(rpipe_out));

	////////////////////////////////////////////////////////////////
	// CPU-side control and compare shadows, readable at once
	// shadows take buffer bits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fast_ctrl_a_r <= `FTAS_RST_BYTE;
			fast_ctrl_b_r <= `FTAS_RST_BYTE;
			fast_ctrl_c_r <= `FTAS_RST_BYTE;
			fast_ctrl_d_r <= `FTAS_RST_BYTE;
			cmp_a_sh_r <= '0;
			cmp_b_sh_r <= '0;
			top_sh_r <= `FTAS_RST_TOP;
			cmp_d_sh_r <= '0;
			timer_irq_mask_r <= `FTAS_RST_BYTE;
			slow_ctrl_r <= `FTAS_RST_BYTE;
		end else if (io_wr) begin
			if (io_addr == `FTAS_A_CTRL_A) fast_ctrl_a_r <= io_wdata;
			else if (io_addr == `FTAS_A_CTRL_B) fast_ctrl_b_r <= io_wdata;
			else if (io_addr == `FTAS_A_CTRL_C) fast_ctrl_c_r <= io_wdata;
			else if (io_addr == `FTAS_A_CTRL_D) fast_ctrl_d_r <= io_wdata;
			else if (io_addr == `FTAS_A_CMP_A) cmp_a_sh_r <= {high_bits_buffer_r, io_wdata};
			else if (io_addr == `FTAS_A_CMP_B) cmp_b_sh_r <= {high_bits_buffer_r, io_wdata};
			else if (io_addr == `FTAS_A_TOP) top_sh_r <= {high_bits_buffer_r, io_wdata};
			else if (io_addr == `FTAS_A_CMP_D) cmp_d_sh_r <= {high_bits_buffer_r, io_wdata};
			else if (io_addr == `FTAS_A_TIMER_IRQ_MASK) timer_irq_mask_r <= io_wdata;
			else if (io_addr == `FTAS_A_SLOW_CTRL) slow_ctrl_r <= io_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Shared high-bits buffer
	// low-byte read fills buffer
	always_comb begin
		hb_nxt = high_bits_buffer_r;
		if (io_wr && io_addr == `FTAS_A_HIGH) hb_nxt = io_wdata[1:0];
		else if (io_rd && io_addr == `FTAS_A_CNT) hb_nxt = fcnt_seen[9:8];
		else if (io_rd && io_addr == `FTAS_A_CMP_A) hb_nxt = cmp_a_sh_r[9:8];
		else if (io_rd && io_addr == `FTAS_A_CMP_B) hb_nxt = cmp_b_sh_r[9:8];
		else if (io_rd && io_addr == `FTAS_A_TOP) hb_nxt = top_sh_r[9:8];
		else if (io_rd && io_addr == `FTAS_A_CMP_D) hb_nxt = cmp_d_sh_r[9:8];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) high_bits_buffer_r <= 2'h0;
		else high_bits_buffer_r <= hb_nxt;
	end

	////////////////////////////////////////////////////////////////
	// Fast side: copies land after the crossing, counter counts up to top
	// writes act after delay
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fa_r <= '0;
			fb_r <= '0;
			ftop_r <= `FTAS_RST_TOP;
			fd_r <= '0;
		end else if (wpipe_out.valid) begin
			if (wpipe_out.data[12:10] == FTAS_W_CMP_A) fa_r <= wpipe_out.data[9:0];
			else if (wpipe_out.data[12:10] == FTAS_W_CMP_B) fb_r <= wpipe_out.data[9:0];
			else if (wpipe_out.data[12:10] == FTAS_W_TOP) ftop_r <= wpipe_out.data[9:0];
			else if (wpipe_out.data[12:10] == FTAS_W_CMP_D) fd_r <= wpipe_out.data[9:0];
		end
	end

	assign fast_at_top = fast_counter_value_r == ftop_r;

	// ten-bit count, cleared at top; a CPU write wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) fast_counter_value_r <= '0;
		else if (wpipe_out.valid && wpipe_out.data[12:10] == FTAS_W_CNT)
			fast_counter_value_r <= wpipe_out.data[9:0];
		else if (fast_run && fast_at_top) fast_counter_value_r <= '0;
		else if (fast_run) fast_counter_value_r <= fast_counter_value_r + 10'h001;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fast_wave_out_a <= 1'b0;
			fast_wave_out_b <= 1'b0;
			fast_wave_out_d <= 1'b0;
		end else if (fast_run) begin
			if (fast_counter_value_r == fa_r) fast_wave_out_a <= !fast_wave_out_a;
			if (fast_counter_value_r == fb_r) fast_wave_out_b <= !fast_wave_out_b;
			if (fast_counter_value_r == fd_r) fast_wave_out_d <= !fast_wave_out_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Slow 8/16-bit timer; capture shares compare A/B storage
	// top is max, compare A, or the compare B:A pair when wide
	assign slow_top = slow_wide ? (slow_ctrl_ctc ? {slow_compare_b_r, slow_compare_a_r} : 16'hffff)
		: {8'h00, (slow_ctrl_ctc ? slow_compare_a_r : `FTAS_MAX)};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) slow_cnt_r <= 16'h0000;
		else if (slow_run && slow_cnt_r == slow_top) slow_cnt_r <= {8'h00, `FTAS_BOTTOM};
		// Eight-bit use wraps at MAX, so a top below the count cannot run away
		else if (slow_run && !slow_wide) slow_cnt_r <= {8'h00, slow_cnt_r[7:0] + 8'h01};
		else if (slow_run) slow_cnt_r <= slow_cnt_r + 16'h0001;
	end

	// Capture overrides a CPU write in the same cycle so no event is lost
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slow_compare_a_r <= `FTAS_RST_BYTE;
			slow_compare_b_r <= `FTAS_RST_BYTE;
		end else if (slow_capm && cap_edge && !slow_ctrl_ctc) begin
			slow_compare_a_r <= slow_cnt_r[7:0];
			if (slow_wide) slow_compare_b_r <= slow_cnt_r[15:8];
		end else if (io_wr && io_addr == `FTAS_A_SLOW_CMP_A) slow_compare_a_r <= io_wdata;
		else if (io_wr && io_addr == `FTAS_A_SLOW_CMP_B) slow_compare_b_r <= io_wdata;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) cap_prev_r <= 1'b0;
		else cap_prev_r <= capture_input_pin;
	end

	////////////////////////////////////////////////////////////////
	// Flag set terms
	always_comb begin
		timer_interrupt_flags_set = 8'h00;
		timer_interrupt_flags_set[`FTAS_B_FD] = fast_run && fast_counter_value_r == fd_r;
		timer_interrupt_flags_set[`FTAS_B_FA] = fast_run && fast_counter_value_r == fa_r;
		timer_interrupt_flags_set[`FTAS_B_FB] = fast_run && fast_counter_value_r == fb_r;
		timer_interrupt_flags_set[`FTAS_B_FOVF] = fast_run && fast_at_top;
		timer_interrupt_flags_set[`FTAS_B_SA] = slow_run && !slow_capm && (slow_wide
			? slow_cnt_r == {slow_compare_b_r, slow_compare_a_r} : slow_cnt_r[7:0] == slow_compare_a_r);
		timer_interrupt_flags_set[`FTAS_B_SB] = slow_run && !slow_wide && slow_cnt_r[7:0] == slow_compare_b_r;
		timer_interrupt_flags_set[`FTAS_B_SOVF] = slow_run && (slow_wide ? slow_cnt_r == 16'hffff
			: slow_cnt_r[7:0] == `FTAS_MAX) && !slow_ctrl_ctc;
		// capture edge, or top when capture is top
		timer_interrupt_flags_set[`FTAS_B_CAP] = slow_capm && (slow_ctrl_ctc ? slow_run && slow_cnt_r == slow_top : cap_edge);
	end

	// clear by one or vector; set wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) timer_interrupt_flags_r <= `FTAS_RST_BYTE;
		else timer_interrupt_flags_r <= timer_interrupt_flags_set | (timer_interrupt_flags_r
			& ~(wr_timer_interrupt_flags ? io_wdata : 8'h00) & ~irq_vector_ack[7:0]);
	end

	// fault flag lives in control D
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) fault_protect_flag_r <= 1'b0;
		else if (fault_in) fault_protect_flag_r <= 1'b1;
		else if (irq_vector_ack[8] || (io_wr && io_addr == `FTAS_A_CTRL_D && io_wdata[`FTAS_B_FP_FLAG]))
			fault_protect_flag_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) irq_pending <= 9'h000;
		else irq_pending <= {global_irq_enable && fault_protect_flag_r && fast_ctrl_d_r[`FTAS_B_FP_IE],
			{8{global_irq_enable}} & timer_irq_mask_r & timer_interrupt_flags_r};
	end

	////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always_comb begin
		if (io_addr == `FTAS_A_TIMER_INTERRUPT_FLAGS)
			rdata_nxt = {fflags_seen[3:1], timer_interrupt_flags_r[4:3], fflags_seen[0],
				timer_interrupt_flags_r[1:0]};
		else if (io_addr == `FTAS_A_TIMER_IRQ_MASK) rdata_nxt = timer_irq_mask_r;
		else if (io_addr == `FTAS_A_CTRL_A) rdata_nxt = fast_ctrl_a_r;
		else if (io_addr == `FTAS_A_CTRL_B) rdata_nxt = fast_ctrl_b_r;
		else if (io_addr == `FTAS_A_CTRL_C) rdata_nxt = fast_ctrl_c_r;
		else if (io_addr == `FTAS_A_CTRL_D)
			rdata_nxt = {fast_ctrl_d_r[7], fault_protect_flag_r, fast_ctrl_d_r[5:0]};
		else if (io_addr == `FTAS_A_CNT) rdata_nxt = fcnt_seen[7:0];
		else if (io_addr == `FTAS_A_HIGH) rdata_nxt = {6'h00, hb_seen};
		else if (io_addr == `FTAS_A_CMP_A) rdata_nxt = cmp_a_sh_r[7:0];
		else if (io_addr == `FTAS_A_CMP_B) rdata_nxt = cmp_b_sh_r[7:0];
		else if (io_addr == `FTAS_A_TOP) rdata_nxt = top_sh_r[7:0];
		else if (io_addr == `FTAS_A_CMP_D) rdata_nxt = cmp_d_sh_r[7:0];
		else if (io_addr == `FTAS_A_SLOW_CTRL) rdata_nxt = slow_ctrl_r;
		else if (io_addr == `FTAS_A_SLOW_CMP_A) rdata_nxt = slow_compare_a_r;
		else if (io_addr == `FTAS_A_SLOW_CMP_B) rdata_nxt = slow_compare_b_r;
		else rdata_nxt = 8'h00;
	end

	// Data hold their last value between reads
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) io_rdata <= 8'h00;
		else if (io_rd) io_rdata <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////
	// Assertions
	property p_hb_copy;
		@(posedge clk) disable iff (!nrst) io_rd && !io_wr && io_addr == `FTAS_A_CMP_A
			|=> high_bits_buffer_r == $past(cmp_a_sh_r[9:8]);
	endproperty
	a_hb_copy: assert property (p_hb_copy) else $error("buffer not filled on read");

	property p_lo_write;
		@(posedge clk) disable iff (!nrst) io_wr && io_addr == `FTAS_A_CMP_D
			|=> cmp_d_sh_r == {$past(high_bits_buffer_r), $past(io_wdata)};
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("upper bits not from buffer");

	property p_top_clear;
		@(posedge clk) disable iff (!nrst) fast_run && fast_at_top && !wpipe_out.valid
			|=> fast_counter_value_r == 10'h000 && timer_interrupt_flags_r[`FTAS_B_FOVF];
	endproperty
	a_top_clear: assert property (p_top_clear) else $error("counter not cleared at top");

	property p_match_a;
		@(posedge clk) disable iff (!nrst) fast_run && fast_counter_value_r == fa_r
			|=> fast_wave_out_a != $past(fast_wave_out_a) && timer_interrupt_flags_r[`FTAS_B_FA];
	endproperty
	a_match_a: assert property (p_match_a) else $error("match A missed");

	property p_readback;
		@(posedge clk) disable iff (!nrst) (io_wr && io_addr == `FTAS_A_CTRL_A)
			##1 (io_rd && !io_wr && io_addr == `FTAS_A_CTRL_A) |=> io_rdata == $past(io_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("control read back stale");

	property p_clear_one;
		@(posedge clk) disable iff (!nrst) wr_timer_interrupt_flags && io_wdata[`FTAS_B_SOVF] && !timer_interrupt_flags_set[`FTAS_B_SOVF]
			|=> !timer_interrupt_flags_r[`FTAS_B_SOVF];
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("flag not cleared by one");

	property p_zero_keep;
		@(posedge clk) disable iff (!nrst) wr_timer_interrupt_flags && !io_wdata[`FTAS_B_CAP] && !irq_vector_ack[0]
			&& timer_interrupt_flags_r[`FTAS_B_CAP] |=> timer_interrupt_flags_r[`FTAS_B_CAP];
	endproperty
	a_zero_keep: assert property (p_zero_keep) else $error("flag lost on zero write");

	property p_irq_gate;
		@(posedge clk) disable iff (!nrst) irq_pending[`FTAS_B_SOVF] |-> $past(global_irq_enable)
			&& $past(timer_irq_mask_r[`FTAS_B_SOVF]) && $past(timer_interrupt_flags_r[`FTAS_B_SOVF]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without cause");

	property p_slow_wrap;
		@(posedge clk) disable iff (!nrst) slow_run && !slow_wide && !slow_ctrl_ctc && slow_cnt_r[7:0] == 8'hff
			|=> slow_cnt_r == 16'h0000 && timer_interrupt_flags_r[`FTAS_B_SOVF];
	endproperty
	a_slow_wrap: assert property (p_slow_wrap) else $error("slow wrap wrong");

	property p_no_b_wide;
		@(posedge clk) disable iff (!nrst) slow_wide |=> !$rose(timer_interrupt_flags_r[`FTAS_B_SB]);
	endproperty
	a_no_b_wide: assert property (p_no_b_wide) else $error("match B set in wide mode");

	c_top_wrap: cover property (@(posedge clk) disable iff (!nrst) fast_run && fast_at_top);
	c_capture: cover property (@(posedge clk) disable iff (!nrst) slow_capm && cap_edge);
	c_irq: cover property (@(posedge clk) disable iff (!nrst) |irq_pending);
	c_set_clear: cover property (@(posedge clk) disable iff (!nrst) wr_timer_interrupt_flags && |(timer_interrupt_flags_set & io_wdata));
endmodule : ftas_core
`default_nettype wire

// file: core/ftas_sync_stage.sv
// Purpose: Fixed-latency register chain standing for a clock boundary crossing
// Assumes: One clock; latency equals DEPTH cycles
// Notes: Data and valid travel together
`timescale 1ns/1ps
`default_nettype none
module ftas_sync_stage #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic nrst,
	ftas_sync_if.dst din,
	ftas_sync_if.src dout
);
	logic [W-1:0] data_r [DEPTH];
	logic [DEPTH-1:0] valid_r;

	////////////////////////////////////////////////////////////////
	// Shift chain; valid is cleared at reset so nothing leaks out
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			valid_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				data_r[i] <= '0;
			end
		end else begin
			valid_r[0] <= din.valid;
			data_r[0] <= din.data;
			for (int i = 1; i < DEPTH; i++) begin
				valid_r[i] <= valid_r[i-1];
				data_r[i] <= data_r[i-1];
			end
		end
	end

	assign dout.data = data_r[DEPTH-1];
	assign dout.valid = valid_r[DEPTH-1];
endmodule : ftas_sync_stage
`default_nettype wire

// file: dv/fast_timer_access_sync_flags_tb.sv
// Purpose: Self-checking bench for the fast timer access core
// Assumes: 25 MHz clock; the CPU model drives the register strobes
// Notes: Counter, buffer and flag reads wait out the synchronisation delay
`timescale 1ns/1ps
`default_nettype none
`include "ftas_consts.svh"
module fast_timer_access_sync_flags_tb;
	logic clk, nrst, io_wr, io_rd, gie, cap_pin, fault, wa, wb, wd, wa_q, wb_q, wd_q;
	logic [5:0] io_addr;
	logic [7:0] io_wdata, io_rdata, d, v;
	logic [8:0] ack, irq;
	logic [5:0] rw_addr [6] = '{`FTAS_A_CTRL_A, `FTAS_A_CTRL_C, `FTAS_A_CMP_A, `FTAS_A_CMP_B, `FTAS_A_TOP, `FTAS_A_CMP_D};
	int n_fail = 0, comparisons = 0, cyc = 0, tog = 0, tog_b = 0, tog_d = 0;
	////////////////////////////////////////////////////////////
	ftas_cpu_model u_cpu (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata));
	ftas_core #(.SYNC_DEPTH(2)) u_dut (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_enable(gie), .irq_vector_ack(ack),
		.capture_input_pin(cap_pin), .fault_in(fault), .irq_pending(irq), .fast_wave_out_a(wa),
		.fast_wave_out_b(wb), .fast_wave_out_d(wd));
	////////////////////////////////////////////////////////////
	// Clock, timeout ceiling and wave toggle count
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		wa_q <= wa;
		wb_q <= wb;
		wd_q <= wd;
		if (wa !== wa_q && cyc > 10) tog++;
		if (wb !== wb_q && cyc > 10) tog_b++;
		if (wd !== wd_q && cyc > 10) tog_d++;
		if (cyc == 5000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////
	initial begin
		clk = 0;
		nrst = 0;
		gie = 0;
		ack = 9'h000;
		cap_pin = 0;
		fault = 0;
		wa_q = 0;
		wb_q = 0;
		wd_q = 0;
		v = 8'($urandom(79718));
		tick(5);
		nrst = 1;
		// Reset values and an unmapped place
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("flags reset", d, 8'h00);
		u_cpu.rd(`FTAS_A_TOP, d);
		check("top reset", d, 8'hff);
		u_cpu.wr(6'h01, 8'h5a);
		u_cpu.rd(6'h01, d);
		check("unmapped", d, 8'h00);
		foreach (rw_addr[i]) begin
			v = 8'($urandom);
			u_cpu.wr(rw_addr[i], v);
			u_cpu.rd(rw_addr[i], d);
			check("readback", d, v);
		end
		$display("test reset and readback done");
		// High bits travel through the shared buffer both ways
		u_cpu.wr(`FTAS_A_HIGH, 8'h02);
		u_cpu.wr(`FTAS_A_CMP_A, 8'h5a);
		u_cpu.wr(`FTAS_A_HIGH, 8'h00);
		u_cpu.rd(`FTAS_A_CMP_A, d);
		check("cmp a low", d, 8'h5a);
		tick(3);
		u_cpu.rd(`FTAS_A_HIGH, d);
		check("cmp a high", d, 8'h02);
		u_cpu.wr(`FTAS_A_HIGH, 8'h01);
		u_cpu.wr(`FTAS_A_CNT, 8'h33);
		u_cpu.wr(`FTAS_A_HIGH, 8'h00);
		tick(4);
		u_cpu.rd(`FTAS_A_CNT, d);
		check("count low", d, 8'h33);
		tick(3);
		u_cpu.rd(`FTAS_A_HIGH, d);
		check("count high", d, 8'h01);
		$display("test high buffer done");
		// Fast counter in eight-bit use with a short top, then selective flag clearing
		u_cpu.wr(`FTAS_A_HIGH, 8'h00);
		u_cpu.wr(`FTAS_A_TOP, 8'd20);
		u_cpu.wr(`FTAS_A_CMP_A, 8'd5);
		u_cpu.wr(`FTAS_A_CMP_B, 8'd7);
		u_cpu.wr(`FTAS_A_CMP_D, 8'd9);
		u_cpu.wr(`FTAS_A_CNT, 8'h00);
		tog = 0;
		tog_b = 0;
		tog_d = 0;
		u_cpu.wr(`FTAS_A_CTRL_B, 8'h01);
		tick(60);
		u_cpu.wr(`FTAS_A_CTRL_B, 8'h00);
		tick(4);
		check("wave a toggled", 9'(tog > 0), 9'h001);
		check("wave b toggled", 9'(tog_b > 0), 9'h001);
		check("wave d toggled", 9'(tog_d > 0), 9'h001);
		u_cpu.rd(`FTAS_A_CNT, d);
		check("count below top", 9'(d <= 8'd20), 9'h001);
		tick(3);
		u_cpu.rd(`FTAS_A_HIGH, d);
		check("count eight-bit", d, 8'h00);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("fast flags", d & 8'he4, 8'he4);
		u_cpu.wr(`FTAS_A_TIMER_INTERRUPT_FLAGS, 8'h00);
		tick(4);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("zero write", d & 8'he4, 8'he4);
		u_cpu.wr(`FTAS_A_TIMER_INTERRUPT_FLAGS, 8'h40);
		tick(4);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("one write", d & 8'he4, 8'ha4);
		$display("test fast flags done");
		// Slow overflow, interrupt gating and vector clear
		u_cpu.wr(`FTAS_A_TIMER_INTERRUPT_FLAGS, 8'hff);
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h02);
		tick(300);
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h00);
		tick(4);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("slow overflow", d & 8'h02, 8'h02);
		u_cpu.wr(`FTAS_A_TIMER_IRQ_MASK, 8'h02);
		gie = 1;
		tick(3);
		check("irq on", 9'(irq[1]), 9'h001);
		gie = 0;
		tick(3);
		check("irq gated", 9'(irq[1]), 9'h000);
		ack = 9'h002;
		tick(1);
		ack = 9'h000;
		tick(3);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("vector clear", d & 8'h02, 8'h00);
		$display("test slow overflow done");
		// Slow compares with top from compare A, then as a sixteen-bit pair
		u_cpu.wr(`FTAS_A_SLOW_CMP_A, 8'd40);
		u_cpu.wr(`FTAS_A_SLOW_CMP_B, 8'd30);
		u_cpu.wr(`FTAS_A_TIMER_INTERRUPT_FLAGS, 8'hff);
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h03);
		tick(300);
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h01);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("slow matches", d & 8'h1a, 8'h18);
		u_cpu.wr(`FTAS_A_SLOW_CMP_B, 8'h00);
		u_cpu.wr(`FTAS_A_TIMER_INTERRUPT_FLAGS, 8'hff);
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h07);
		tick(100);
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h01);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("wide match", d & 8'h18, 8'h10);
		$display("test slow compares done");
		// Capture edge at a random moment
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h0a);
		tick(1 + $urandom % 20);
		cap_pin = 1;
		tick(2);
		cap_pin = 0;
		u_cpu.wr(`FTAS_A_SLOW_CTRL, 8'h00);
		tick(3);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("capture flag", d & 8'h01, 8'h01);
		u_cpu.wr(`FTAS_A_TIMER_INTERRUPT_FLAGS, 8'h01);
		tick(3);
		u_cpu.rd(`FTAS_A_TIMER_INTERRUPT_FLAGS, d);
		check("capture clear", d & 8'h01, 8'h00);
		$display("test capture done");
		// Fault source with its own enable, interrupts globally on
		gie = 1;
		u_cpu.wr(`FTAS_A_CTRL_D, 8'h80);
		fault = 1;
		tick(1);
		fault = 0;
		tick(3);
		check("fault irq", 9'(irq[8]), 9'h001);
		u_cpu.rd(`FTAS_A_CTRL_D, d);
		check("fault flag", d & 8'h40, 8'h40);
		u_cpu.wr(`FTAS_A_CTRL_D, 8'hc0);
		tick(2);
		u_cpu.rd(`FTAS_A_CTRL_D, d);
		check("fault clear", d & 8'h40, 8'h00);
		$display("test fault done");
		give_verdict();
	end
endmodule : fast_timer_access_sync_flags_tb
`default_nettype wire

// file: dv/ftas_cpu_model.sv
// Purpose: CPU side model driving the I/O register strobes of the core
// Assumes: One clock shared with the core
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module ftas_cpu_model (
	input wire logic clk,
	output logic [5:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata
);
	////////////////////////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		io_addr = 6'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// single shared clock
	// One-cycle strobe; a held strobe would be taken twice
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge clk);
		#1;
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask : wr
	// Samples one edge late, safe whichever edge loads the data
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		io_addr = a;
		io_rd = 1'b1;
		@(posedge clk);
		#1;
		io_rd = 1'b0;
		io_addr = ~a;
		@(posedge clk);
		#1;
		d = io_rdata;
	endtask : rd
endmodule : ftas_cpu_model
`default_nettype wire

// file: include/ftas_consts.svh
// Purpose: Offsets, bit positions, reset values and counts of the fast timer access block
// Assumes: 6-bit I/O address space, 8-bit data
// Notes: Included by bare name
`ifndef FTAS_CONSTS_SVH
`define FTAS_CONSTS_SVH
// I/O offsets
`define FTAS_A_TIMER_INTERRUPT_FLAGS 6'h38
`define FTAS_A_TIMER_IRQ_MASK 6'h39
`define FTAS_A_CTRL_A 6'h30
`define FTAS_A_CTRL_B 6'h2f
`define FTAS_A_CNT 6'h2e
`define FTAS_A_CMP_A 6'h2d
`define FTAS_A_CMP_B 6'h2c
`define FTAS_A_TOP 6'h2b
`define FTAS_A_SLOW_CTRL 6'h2a
`define FTAS_A_CTRL_C 6'h27
`define FTAS_A_CTRL_D 6'h26
`define FTAS_A_HIGH 6'h25
`define FTAS_A_CMP_D 6'h22
`define FTAS_A_SLOW_CMP_A 6'h13
`define FTAS_A_SLOW_CMP_B 6'h12
// Flag and mask bit positions (same layout in both registers)
`define FTAS_B_FD 7
`define FTAS_B_FA 6
`define FTAS_B_FB 5
`define FTAS_B_SA 4
`define FTAS_B_SB 3
`define FTAS_B_FOVF 2
`define FTAS_B_SOVF 1
`define FTAS_B_CAP 0
// Control bit positions
`define FTAS_B_FRUN 0
`define FTAS_B_FP_FLAG 6
`define FTAS_B_FP_IE 7
`define FTAS_B_SCTC 0
`define FTAS_B_SRUN 1
`define FTAS_B_SWIDE 2
`define FTAS_B_SCAPM 3
// Reset values
`define FTAS_RST_BYTE 8'h00
`define FTAS_RST_TOP 10'h0ff
// Counter limits of the slow timer
`define FTAS_BOTTOM 8'h00
`define FTAS_MAX 8'hff
// Stages of each synchronisation path
`define FTAS_SYNC_DEPTH 2
`endif

// file: include/ftas_pkg.sv
// Purpose: Types shared by the fast timer access block
// Assumes: Nothing
// Notes: Write targets ride the write synchronisation path
package ftas_pkg;
	typedef enum logic [2:0] {
		FTAS_W_NONE,
		FTAS_W_CNT,
		FTAS_W_CMP_A,
		FTAS_W_CMP_B,
		FTAS_W_TOP,
		FTAS_W_CMP_D
	} ftas_wtgt_t;
	typedef logic [12:0] ftas_wpay_t;
endpackage : ftas_pkg

// file: include/ftas_sync_if.sv
// Purpose: Word plus valid carried between synchronisation stages
// Assumes: Single clock
// Notes: src drives, dst listens
`timescale 1ns/1ps
`default_nettype none
interface ftas_sync_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic valid;
	modport src (output data, output valid);
	modport dst (input data, input valid);
endinterface : ftas_sync_if
`default_nettype wire
